// [gov_params.svh]
`ifndef GOV_PARAMS_SVH
`define GOV_PARAMS_SVH
// clock and time base
`define CLK_HZ 40000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
// longest speed-loss timeout, 0.5 s, in ms
`define LOST_MAX_MS 500
// register byte addresses
`define A_CTRL 12'h000
`define A_START_THR 12'h004
`define A_RUN_THR 12'h008
`define A_OVS_THR 12'h00C
`define A_LOST_TO 12'h010
`define A_START_LIM 12'h014
`define A_POS_CMD 12'h018
`define A_GAINS 12'h01C
`define A_STATUS 12'h020
`define A_FAULT_LOG 12'h024
`define A_KEY 12'h028
`define A_UNLOCK 12'h02C
// control field positions
`define C_OVS_EN 0
`define C_LOST_EN 1
`define C_RELAY_EN 2
`define C_LOG_EN 3
`define C_SLIM_EN 4
`define C_DIR 5
// fault log bit positions
`define L_CFG 0
`define L_OVS 1
`define L_LOST 2
// reset values
`define R_CTRL 6'h1F
`define R_START_THR 16'h0064
`define R_RUN_THR 16'h0320
`define R_OVS_THR 16'h0800
`define R_LOST_TO 9'h064
`define R_START_LIM 12'h400
`define R_GAINS 24'h040410
// torque ends
`define TQ_MAX 16'h7FFF
`define TQ_MIN 16'h8000
`endif

// [gov_pkg.sv]
package gov_pkg;
   // supervisory states
   typedef enum logic [1:0] {ST_POWERUP, ST_START, ST_RUN, ST_ERROR} gov_state_t;
   // position loop state
   typedef struct packed {
      logic signed [19:0] integ;
      logic signed [12:0] e_prev;
      logic [15:0] torque;
   } pid_st_t;
   // supervisor state
   typedef struct packed {
      logic [5:0] ctrl;
      logic [15:0] start_thr;
      logic [15:0] run_thr;
      logic [15:0] ovs_thr;
      logic [8:0] lost_to;
      logic [11:0] start_lim;
      logic [11:0] pos_cmd;
      logic [23:0] gains;
      logic [15:0] key;
      logic [15:0] unlock;
      gov_state_t state;
      logic checked;
      logic cfg_f;
      logic ovs_f;
      logic lost_f;
      logic [2:0] log;
      logic s1;
      logic s2;
      logic s3;
      logic spd_lvl;
      logic [15:0] tick_cnt;
      logic [8:0] ms_cnt;
      logic [15:0] torque;
      logic relay_oe;
      logic nv_we;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sup_st_t;
endpackage : gov_pkg

// [pid_torque.sv]
`timescale 1ns/100ps
`include "gov_params.svh"
module pid_torque
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic enable, // loop running
   input wire logic [11:0] pos_cmd, // wanted position
   input wire logic [11:0] pos_meas, // measured position
   input wire logic [7:0] kp, // proportional gain
   input wire logic [7:0] ki, // integral gain
   input wire logic [7:0] kd, // derivative gain
   output logic [15:0] torque // signed torque command
);
   gov_pkg::pid_st_t st; // registered state
   gov_pkg::pid_st_t nx; // next state
   logic signed [12:0] err; // position error
   logic signed [31:0] acc; // weighted sum

   // error, three terms, scale and saturate
   always_comb
   begin
      nx = st;
      err = $signed({1'b0, pos_cmd}) - $signed({1'b0, pos_meas});
      acc = 32'sd0;
      if (!enable)
      begin
         nx.integ = 20'sd0;
         nx.e_prev = 13'sd0;
         nx.torque = 16'h0000;
      end
      else
      begin
         acc = 32'($signed({1'b0, kp}) * err) + 32'($signed({1'b0, ki}) * st.integ) / 32'sd16
            + 32'($signed({1'b0, kd}) * 32'(err - st.e_prev));
         acc = acc >>> 4;
         // hold integrator at its last value when the sum would pass +/-3FFFF, to avoid windup
         if (st.integ + 20'(err) > 20'sh3FFFF || st.integ + 20'(err) < -20'sh3FFFF)
            nx.integ = st.integ;
         else
            nx.integ = st.integ + 20'(err);
         nx.e_prev = err;
         if (acc > 32'sh7FFF)
            nx.torque = `TQ_MAX;
         else if (acc < -32'sh8000)
            nx.torque = `TQ_MIN;
         else
            nx.torque = acc[15:0];
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else
         st <= nx;
   end

   assign torque = st.torque;
endmodule : pid_torque

// [gov_supervisor.sv]
`timescale 1ns/100ps
`include "gov_params.svh"
module gov_supervisor
#(
   parameter int TICK_CYCLES = `TICK_CYCLES // cycles per ms tick
)
(
   input wire logic pclk, // 40 MHz clock
   input wire logic presetn, // async reset, low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [15:0] speed_value, // measured engine speed
   input wire logic speed_pulse_pin, // raw speed pulse pin
   input wire logic [11:0] pos_meas, // measured actuator position
   input wire logic cfg_image_ok, // configuration image present
   input wire logic [2:0] nv_log_in, // stored fault log at power-up
   output logic [15:0] torque_cmd, // signed actuator torque
   output logic relay_o, // relay pin level, always low
   output logic relay_oe, // relay pin sinking
   output logic [2:0] nv_log_out, // fault log to storage
   output logic nv_log_we, // storage write pulse
   output logic [1:0] gov_state // supervisory state
);
   gov_pkg::sup_st_t st; // registered state
   gov_pkg::sup_st_t nx; // next state
   logic [15:0] pid_tq; // loop torque
   logic [11:0] cmd_eff; // limited position command
   logic loop_on; // loop running
   logic pulse; // speed pulse seen
   logic tick; // ms enable
   logic armed; // detectors live
   logic locked; // protected reads refused
   logic prot; // protected address
   logic [8:0] lim; // effective timeout

   // refuse tick counts the divider cannot hold
   if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
      $error("tick count out of range");

   // start fuel limit caps command before run
   always_comb
   begin
      cmd_eff = st.pos_cmd;
      if (st.state == gov_pkg::ST_START && st.ctrl[`C_SLIM_EN] && st.pos_cmd > st.start_lim)
         cmd_eff = st.start_lim;
   end
   assign loop_on = (st.state == gov_pkg::ST_START) || (st.state == gov_pkg::ST_RUN);

   pid_torque u_pid
   (
      .pclk(pclk),
      .presetn(presetn),
      .enable(loop_on),
      .pos_cmd(cmd_eff),
      .pos_meas(pos_meas),
      .kp(st.gains[23:16]),
      .ki(st.gains[15:8]),
      .kd(st.gains[7:0]),
      .torque(pid_tq)
   );

   // all next-state logic
   always_comb
   begin
      nx = st;
      nx.nv_we = 1'b0;
      nx.pready = 1'b0;
      nx.pslverr = 1'b0;
      // three-stage pin synchroniser
      nx.s1 = speed_pulse_pin;
      nx.s2 = st.s1;
      nx.s3 = st.s2;
      if (st.s2 == st.s3)
         nx.spd_lvl = st.s3;
      pulse = nx.spd_lvl & ~st.spd_lvl;
      // ms divider
      tick = (st.tick_cnt == 16'(TICK_CYCLES - 1));
      nx.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
      // one-shot check after reset release
      if (!st.checked)
      begin
         nx.checked = 1'b1;
         nx.cfg_f = ~cfg_image_ok;
         nx.log = nv_log_in;
      end
      // timeout clamped to 0.5 s, never zero
      lim = (st.lost_to > 9'(`LOST_MAX_MS)) ? 9'(`LOST_MAX_MS) : st.lost_to;
      if (lim == 9'h000)
         lim = 9'h001;
      armed = (st.state == gov_pkg::ST_RUN);
      if (!armed || pulse)
         nx.ms_cnt = 9'h000;
      else if (tick && st.ms_cnt < lim)
         nx.ms_cnt = st.ms_cnt + 9'h001;
      // fault detectors, strict compare for overspeed, speed loss at or above limit
      if (armed && st.ctrl[`C_OVS_EN] && speed_value > st.ovs_thr)
         nx.ovs_f = 1'b1;
      if (armed && st.ctrl[`C_LOST_EN] && st.ms_cnt >= lim)
         nx.lost_f = 1'b1;
      // supervisory state machine
      unique case (st.state)
         gov_pkg::ST_POWERUP:
         begin
            if (st.checked && st.cfg_f)
               nx.state = gov_pkg::ST_ERROR;
            else if (st.checked && speed_value > st.start_thr)
               nx.state = gov_pkg::ST_START;
         end
         gov_pkg::ST_START:
         begin
            if (speed_value > st.run_thr)
               nx.state = gov_pkg::ST_RUN;
         end
         gov_pkg::ST_RUN:
         begin
            if (st.ovs_f || st.lost_f)
               nx.state = gov_pkg::ST_ERROR;
         end
         gov_pkg::ST_ERROR:
         begin
            nx.state = gov_pkg::ST_ERROR;
         end
      endcase
      // torque gate by state
      unique case (st.state)
         gov_pkg::ST_POWERUP: nx.torque = 16'h0000;
         gov_pkg::ST_START, gov_pkg::ST_RUN: nx.torque = pid_tq;
         gov_pkg::ST_ERROR: nx.torque = st.ctrl[`C_DIR] ? `TQ_MAX : `TQ_MIN;
      endcase
      // relay sinks on config fault, or on overspeed or speed loss when relay enabled
      nx.relay_oe = st.cfg_f | (st.ctrl[`C_RELAY_EN] & (st.ovs_f | st.lost_f));
      // apb setup phase: decode and answer next cycle
      locked = (st.key != 16'h0000) && (st.unlock != st.key);
      prot = (paddr <= `A_GAINS) || (paddr == `A_FAULT_LOG);
      if (psel && !penable)
      begin
         nx.pready = 1'b1;
         nx.prdata = 32'h00000000;
         if (locked && prot && !pwrite)
            nx.pslverr = 1'b1;
         else if (locked && pwrite && paddr == `A_KEY)
            nx.pslverr = 1'b1;
         else
         begin
            unique case (paddr)
               `A_CTRL: nx.prdata = 32'(st.ctrl);
               `A_START_THR: nx.prdata = 32'(st.start_thr);
               `A_RUN_THR: nx.prdata = 32'(st.run_thr);
               `A_OVS_THR: nx.prdata = 32'(st.ovs_thr);
               `A_LOST_TO: nx.prdata = 32'(st.lost_to);
               `A_START_LIM: nx.prdata = 32'(st.start_lim);
               `A_POS_CMD: nx.prdata = 32'(st.pos_cmd);
               `A_GAINS: nx.prdata = 32'(st.gains);
               `A_STATUS: nx.prdata = {24'h000000, st.lost_f, st.ovs_f, st.cfg_f, st.relay_oe,
                  locked, st.checked, st.state};
               `A_FAULT_LOG: nx.prdata = 32'(st.log);
               `A_KEY, `A_UNLOCK: nx.prdata = 32'h00000000;
               default: nx.pslverr = 1'b1;
            endcase
         end
      end
      // apb access phase: write takes effect
      if (psel && penable && st.pready && pwrite && !st.pslverr)
      begin
         unique case (paddr)
            `A_CTRL: nx.ctrl = pwdata[5:0];
            `A_START_THR: nx.start_thr = pwdata[15:0];
            `A_RUN_THR: nx.run_thr = pwdata[15:0];
            `A_OVS_THR: nx.ovs_thr = pwdata[15:0];
            `A_LOST_TO: nx.lost_to = pwdata[8:0];
            `A_START_LIM: nx.start_lim = pwdata[11:0];
            `A_POS_CMD: nx.pos_cmd = pwdata[11:0];
            `A_GAINS: nx.gains = pwdata[23:0];
            `A_FAULT_LOG: nx.log = nx.log & ~pwdata[2:0];
            `A_KEY: nx.key = pwdata[15:0];
            `A_UNLOCK: nx.unlock = pwdata[15:0];
            default: ;
         endcase
         if (paddr == `A_FAULT_LOG)
            nx.nv_we = 1'b1;
      end
      // log fault source on entry to error; set beats clear
      if (nx.state == gov_pkg::ST_ERROR && st.state != gov_pkg::ST_ERROR && st.ctrl[`C_LOG_EN])
      begin
         nx.log = nx.log | {st.lost_f, st.ovs_f, st.cfg_f};
         nx.nv_we = 1'b1;
      end
   end

   // state register, powerup on reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
         st.state <= gov_pkg::ST_POWERUP;
         st.ctrl <= `R_CTRL;
         st.start_thr <= `R_START_THR;
         st.run_thr <= `R_RUN_THR;
         st.ovs_thr <= `R_OVS_THR;
         st.lost_to <= `R_LOST_TO;
         st.start_lim <= `R_START_LIM;
         st.gains <= `R_GAINS;
      end
      else
         st <= nx;
   end

   // outputs straight from flops, relay_o tied low
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign torque_cmd = st.torque;
   assign relay_o = 1'b0;
   assign relay_oe = st.relay_oe;
   assign nv_log_out = st.log;
   assign nv_log_we = st.nv_we;
   assign gov_state = st.state;

   // checks of the supervisory behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pu_zero;
      st.state == gov_pkg::ST_POWERUP |=> torque_cmd == 16'h0000;
   endproperty
   a_pu_zero: assert property (p_pu_zero) else $error("torque not zero in powerup");

   property p_pass;
      loop_on |=> torque_cmd == $past(pid_tq);
   endproperty
   a_pass: assert property (p_pass) else $error("loop torque not forwarded");

   property p_minfuel;
      st.state == gov_pkg::ST_ERROR |=> torque_cmd == ($past(st.ctrl[`C_DIR]) ? `TQ_MAX : `TQ_MIN);
   endproperty
   a_minfuel: assert property (p_minfuel) else $error("error torque not at minimum fuel");

   property p_sticky;
      st.state == gov_pkg::ST_ERROR |=> st.state == gov_pkg::ST_ERROR;
   endproperty
   a_sticky: assert property (p_sticky) else $error("left error state");

   property p_to_start;
      st.state == gov_pkg::ST_POWERUP && st.checked && !st.cfg_f && speed_value > st.start_thr
         |=> st.state == gov_pkg::ST_START;
   endproperty
   a_to_start: assert property (p_to_start) else $error("no move to start");

   property p_to_run;
      st.state == gov_pkg::ST_START && speed_value > st.run_thr |=> st.state == gov_pkg::ST_RUN;
   endproperty
   a_to_run: assert property (p_to_run) else $error("no move to run");

   sequence s_trip;
      st.ovs_f ##1 st.state == gov_pkg::ST_ERROR ##1 torque_cmd != 16'h0000;
   endsequence
   property p_ovs;
      armed && st.ctrl[`C_OVS_EN] && speed_value > st.ovs_thr |=> s_trip;
   endproperty
   a_ovs: assert property (p_ovs) else $error("overspeed not handled");

   property p_relay_idle;
      !st.cfg_f && !st.ovs_f && !st.lost_f |=> !relay_oe;
   endproperty
   a_relay_idle: assert property (p_relay_idle) else $error("relay active without fault");

   property p_lost_armed;
      $rose(st.lost_f) |-> $past(st.state) == gov_pkg::ST_RUN && $past(st.ms_cnt) <= 9'(`LOST_MAX_MS);
   endproperty
   a_lost_armed: assert property (p_lost_armed) else $error("speed loss outside run or late");

   property p_log;
      st.state == gov_pkg::ST_RUN && nx.state == gov_pkg::ST_ERROR && st.ctrl[`C_LOG_EN]
         |=> nv_log_we && (nv_log_out & {$past(st.lost_f), $past(st.ovs_f), 1'b0}) != 3'h0;
   endproperty
   a_log: assert property (p_log) else $error("fault source not logged");

   property p_lock;
      psel && !penable && !pwrite && locked && prot |=> pslverr && prdata == 32'h00000000;
   endproperty
   a_lock: assert property (p_lock) else $error("locked read not refused");
endmodule : gov_supervisor

// [gov_far_side.sv]
`timescale 1ns/100ps
// speed pickup, actuator and relay wiring seen by the supervisor
module gov_far_side
#(
   parameter int GAP = 8 // cycles between speed pulses
)
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic pulse_en, // engine turning
   input wire logic [15:0] torque_cmd, // torque from supervisor
   input wire logic relay_o, // relay drive level
   input wire logic relay_oe, // relay sinking
   output logic speed_pulse_pin, // pickup pulses
   output logic [11:0] pos_meas, // actuator position
   output logic relay_line // relay wire level
);
   int cnt; // pulse spacing counter
   // pull-up to the weak supply while floating
   assign relay_line = relay_oe ? relay_o : 1'b1;
   // pickup pulses only while turning, idle low
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt <= 0;
         speed_pulse_pin <= 1'b0;
      end
      else
      begin
         cnt <= (cnt >= GAP - 1) ? 0 : cnt + 1;
         speed_pulse_pin <= pulse_en && (cnt < GAP / 2);
      end
   // actuator creeps in the direction of the torque
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pos_meas <= 12'h000;
      else if (torque_cmd != 16'h0000)
         pos_meas <= torque_cmd[15] ? pos_meas - 12'h001 : pos_meas + 12'h001;
endmodule : gov_far_side

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
   logic pclk; // bus clock
   logic presetn; // reset, low
   logic [11:0] paddr; // apb address
   logic psel, penable, pwrite; // apb controls
   logic [31:0] pwdata, prdata; // apb data
   logic pready, pslverr; // apb answer
   logic [15:0] speed_value; // engine speed
   logic speed_pulse_pin, relay_o, relay_oe, relay_line; // pins
   logic [11:0] pos_meas; // actuator position
   logic cfg_image_ok; // config present
   logic [2:0] nv_log_in, nv_log_out; // fault log
   logic nv_log_we, seen_we, pulse_en; // log strobe, monitor, pickup on
   logic [15:0] torque_cmd; // torque to actuator
   logic [1:0] gov_state; // supervisor state
   int n_mismatch = 0; // mismatches
   int compares = 0; // comparisons
   logic [31:0] rv [8] = '{32'h1F, 32'h64, 32'h320, 32'h800, 32'h64, 32'h400, 32'h0, 32'h040410}; // reset table
   gov_supervisor #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_value(speed_value), .speed_pulse_pin(speed_pulse_pin), .pos_meas(pos_meas),
      .cfg_image_ok(cfg_image_ok), .nv_log_in(nv_log_in), .torque_cmd(torque_cmd), .relay_o(relay_o),
      .relay_oe(relay_oe), .nv_log_out(nv_log_out), .nv_log_we(nv_log_we), .gov_state(gov_state));
   gov_far_side far (.pclk(pclk), .presetn(presetn), .pulse_en(pulse_en), .torque_cmd(torque_cmd),
      .relay_o(relay_o), .relay_oe(relay_oe), .speed_pulse_pin(speed_pulse_pin), .pos_meas(pos_meas),
      .relay_line(relay_line));
   // clock generator
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // sticky record of log store strobes, cleared by reset
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         seen_we <= 1'b0;
      else if (nv_log_we === 1'b1)
         seen_we <= 1'b1;
   // compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // end of run
   task automatic give_verdict;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer; only the watchdog ends a hang
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // read and compare data and error
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask : rd_chk
   // write and compare error
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      check({31'h0, err}, {31'h0, exp_err});
   endtask : wr_chk
   // wait for a state, at most lim cycles
   task automatic wait_state(input logic [1:0] st, input int lim);
      int n;
      n = 0;
      while (gov_state !== st && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      check({30'h0, gov_state}, {30'h0, st});
   endtask : wait_state
   // reset with a given config and stored log
   task automatic do_reset(input logic ok, input logic [2:0] log_in);
      @(posedge pclk);
      presetn <= 1'b0;
      cfg_image_ok <= ok;
      nv_log_in <= log_in;
      speed_value <= 16'h0000;
      pulse_en <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : do_reset
   // watchdog
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      give_verdict();
   end
   // test sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pulse_en} = '0;
      {speed_value, nv_log_in} = '0;
      cfg_image_ok = 1'b1;
      do_reset(1'b1, 3'b000);
      check({30'h0, gov_state}, 32'h0);
      for (int i = 0; i < 8; i++)
         rd_chk(12'(4 * i), rv[i], 1'b0);
      rd_chk(12'h030, 32'h0, 1'b1);
      $display("test reset values done");
      speed_value <= 16'h0064;
      repeat (10) @(posedge pclk);
      check({30'h0, gov_state}, 32'h0);
      check({16'h0, torque_cmd}, 32'h0);
      speed_value <= 16'h0065;
      pulse_en <= 1'b1;
      wait_state(2'd1, 5);
      speed_value <= 16'h0320;
      repeat (10) @(posedge pclk);
      check({30'h0, gov_state}, 32'h1);
      speed_value <= 16'h0321;
      wait_state(2'd2, 5);
      check({31'h0, relay_line}, 32'h1);
      speed_value <= 16'h0801;
      wait_state(2'd3, 5);
      repeat (3) @(posedge pclk);
      check({16'h0, torque_cmd}, 32'h8000);
      check({31'h0, relay_line}, 32'h0);
      check({29'h0, nv_log_out}, 32'h2);
      check({31'h0, seen_we}, 32'h1);
      speed_value <= 16'h0000;
      repeat (20) @(posedge pclk);
      check({30'h0, gov_state}, 32'h3);
      $display("test overspeed done");
      do_reset(1'b1, 3'b010);
      check({30'h0, gov_state}, 32'h0);
      rd_chk(12'h024, 32'h2, 1'b0);
      wr_chk(12'h024, 32'h2, 1'b0);
      rd_chk(12'h024, 32'h0, 1'b0);
      wr_chk(12'h000, 32'h3B, 1'b0);
      wr_chk(12'h010, 32'h3, 1'b0);
      pulse_en <= 1'b1;
      speed_value <= 16'h0321;
      wait_state(2'd1, 5);
      wait_state(2'd2, 5);
      wr_chk(12'h018, 32'h100, 1'b0);
      repeat (3) @(posedge pclk);
      check({31'h0, torque_cmd != 16'h0000 && !torque_cmd[15]}, 32'h1);
      repeat (60) @(posedge pclk);
      check({30'h0, gov_state}, 32'h2);
      pulse_en <= 1'b0;
      repeat (8) @(posedge pclk);
      check({30'h0, gov_state}, 32'h2);
      wait_state(2'd3, 30);
      repeat (3) @(posedge pclk);
      check({29'h0, nv_log_out}, 32'h4);
      check({31'h0, relay_oe}, 32'h0);
      check({16'h0, torque_cmd}, 32'h7FFF);
      $display("test speed loss done");
      wr_chk(12'h028, 32'h1234, 1'b0);
      rd_chk(12'h000, 32'h0, 1'b1);
      wr_chk(12'h02C, 32'h1234, 1'b0);
      rd_chk(12'h000, 32'h3B, 1'b0);
      $display("test access key done");
      do_reset(1'b0, 3'b000);
      wait_state(2'd3, 5);
      speed_value <= 16'h0065;
      repeat (10) @(posedge pclk);
      check({30'h0, gov_state}, 32'h3);
      check({31'h0, relay_line}, 32'h0);
      check({29'h0, nv_log_out}, 32'h1);
      $display("test config fault done");
      give_verdict();
   end
endmodule : testbench
